// file: verilog/swe_prio_learn_regs.sv
// Switch engine register slice: port 2 priority regeneration, learn discard counts, interrupt mask
// Notes on behaviour
// - Port 2 received priority is replaced by its table field to pick the queue.
// - Table holds eight 3-bit fields at bits 3k+2:3k; bits 31:24 read zero.
// - Table fields reset to the identity mapping, seven down to zero.
// - Each port counts addresses not learned or overwritten for lack of table space.
// - Counters reset to zero; a read returns the count and clears it.
// - Counters stop at all ones and never wrap.
// - Mask bit set blocks all switch engine interrupts; cleared lets them through.
// - Mask affects only the interrupt output, never the pending status bits.
// - Mask bit resets to one; bits 31:1 read zero.
// - Pending status is double buffered and fully gated by the one mask bit.
`timescale 1ns/10ps
`include "swe_regs_defines.svh"
module swe_prio_learn_regs (
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire swe_regs_pkg::reg_req_t reg_req,
   output swe_regs_pkg::reg_rsp_t     reg_rsp,
   input  wire swe_regs_pkg::prio_t   rx_prio,
   output swe_regs_pkg::prio_t        regen_prio,
   input  wire logic [2:0]            learn_discard,
   input  wire logic                  irq_pending_any,
   output logic                       switch_irq_req,
   output logic                       switch_irq_mask_out
);
   import swe_regs_pkg::*;

   typedef struct packed {
      logic [23:0] regen_table;
      logic        irq_mask;
      logic        pend_stage;
      logic        irq_req;
      reg_rsp_t    rsp;
   } top_state_t;

   top_state_t  state_reg;
   top_state_t  state_next;
   logic [31:0] discard_count [3];
   logic [2:0]  clear_rd;
   logic [15:0] port_ofs [3];
   logic        addr_mapped;

   assign port_ofs[0] = `OFS_PORT0_DISCARD;
   assign port_ofs[1] = `OFS_PORT1_DISCARD;
   assign port_ofs[2] = `OFS_PORT2_DISCARD;
   assign addr_mapped = reg_req.addr inside {`OFS_PORT2_REGEN, `OFS_PORT0_DISCARD, `OFS_PORT1_DISCARD,
                                             `OFS_PORT2_DISCARD, `OFS_IRQ_MASK};

   // One saturating counter per port
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cnt
         assign clear_rd[gi] = reg_req.rd && reg_req.addr == port_ofs[gi];
         discard_counter u_cnt (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .event_in (learn_discard[gi]),
            .clear_rd (clear_rd[gi]),
            .count    (discard_count[gi])
         );

         property p_read_set_wins;
            @(posedge core_clk) disable iff (!rst_n)
            (clear_rd[gi] && learn_discard[gi]) |=> discard_count[gi] == 32'h0000_0001
               && reg_rsp.rdata == $past(discard_count[gi]);
         endproperty
         a_read_set_wins: assert property (p_read_set_wins) else $error("Event lost during clearing read");

         property p_count_still;
            @(posedge core_clk) disable iff (!rst_n)
            (!clear_rd[gi] && !learn_discard[gi]) |=> $stable(discard_count[gi]);
         endproperty
         a_count_still: assert property (p_count_still) else $error("Discard counter moved without event");

         property p_count_read;
            @(posedge core_clk) disable iff (!rst_n)
            clear_rd[gi] |=> reg_rsp.valid && reg_rsp.rdata == $past(discard_count[gi]);
         endproperty
         a_count_read: assert property (p_count_read) else $error("Counter read returned wrong value");
      end
   endgenerate

   prio_regen_map u_map (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .table_bits (state_reg.regen_table),
      .rx_prio    (rx_prio),
      .regen_prio (regen_prio)
   );

   property p_regen_idle;
      @(posedge core_clk) disable iff (!rst_n)
      !rx_prio.valid |=> !regen_prio.valid;
   endproperty
   a_regen_idle: assert property (p_regen_idle) else $error("Regenerated priority valid without input");

   // One lookup and reset check per table entry
   genvar ki;
   generate
      for (ki = 0; ki < 8; ki++) begin : g_entry
         property p_entry_reset;
            @(posedge core_clk)
            $rose(rst_n) |-> state_reg.regen_table[ki*`REGEN_FIELD_W +: `REGEN_FIELD_W] == 3'(ki);
         endproperty
         a_entry_reset: assert property (p_entry_reset) else $error("Table entry reset value wrong");

         property p_entry_map;
            @(posedge core_clk) disable iff (!rst_n)
            (rx_prio.valid && rx_prio.prio == 3'(ki))
               |=> regen_prio.prio == $past(state_reg.regen_table[ki*`REGEN_FIELD_W +: `REGEN_FIELD_W]);
         endproperty
         a_entry_map: assert property (p_entry_map) else $error("Table entry lookup wrong");
      end
   endgenerate

   always_comb begin
      state_next           = state_reg;
      state_next.rsp.valid = reg_req.rd;
      state_next.rsp.rdata = 32'h0000_0000;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            `OFS_PORT2_REGEN: state_next.regen_table = reg_req.wdata[`REGEN_USED_W-1:0];
            `OFS_IRQ_MASK:    state_next.irq_mask = reg_req.wdata[`IRQ_MASK_BIT];
            default: ;
         endcase
      end
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            `OFS_PORT2_REGEN:   state_next.rsp.rdata = {8'h00, state_reg.regen_table};
            `OFS_PORT0_DISCARD: state_next.rsp.rdata = discard_count[0];
            `OFS_PORT1_DISCARD: state_next.rsp.rdata = discard_count[1];
            `OFS_PORT2_DISCARD: state_next.rsp.rdata = discard_count[2];
            `OFS_IRQ_MASK:      state_next.rsp.rdata = {31'h0000_0000, state_reg.irq_mask};
            default:            state_next.rsp.rdata = 32'h0000_0000;
         endcase
      end
      // Status staged once more before the gate; status itself never touched by the mask
      state_next.pend_stage = irq_pending_any;
      state_next.irq_req    = state_reg.pend_stage && !state_reg.irq_mask;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg.regen_table <= `RST_REGEN_TABLE;
         state_reg.irq_mask    <= `RST_IRQ_MASK;
         state_reg.pend_stage  <= 1'b0;
         state_reg.irq_req     <= 1'b0;
         state_reg.rsp         <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rsp             = state_reg.rsp;
   assign switch_irq_req      = state_reg.irq_req;
   assign switch_irq_mask_out = state_reg.irq_mask;

   sequence s_mask_read;
      reg_req.rd && reg_req.addr == `OFS_IRQ_MASK;
   endsequence

   property p_mask_blocks;
      @(posedge core_clk) disable iff (!rst_n)
      state_reg.irq_mask [*2] |=> !switch_irq_req;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) else $error("Interrupt passed while masked");

   property p_irq_pass;
      @(posedge core_clk) disable iff (!rst_n)
      (irq_pending_any && !state_reg.irq_mask) ##1 !state_reg.irq_mask |=> switch_irq_req;
   endproperty
   a_irq_pass: assert property (p_irq_pass) else $error("Unmasked pending interrupt not raised");

   property p_mask_read;
      @(posedge core_clk) disable iff (!rst_n)
      s_mask_read |=> reg_rsp.valid && reg_rsp.rdata[31:1] == 31'h0000_0000
         && reg_rsp.rdata[0] == $past(state_reg.irq_mask);
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("Mask read value wrong");

   property p_regen_read;
      @(posedge core_clk) disable iff (!rst_n)
      (reg_req.rd && reg_req.addr == `OFS_PORT2_REGEN) |=> reg_rsp.rdata[31:24] == 8'h00
         && reg_rsp.rdata[23:0] == $past(state_reg.regen_table);
   endproperty
   a_regen_read: assert property (p_regen_read) else $error("Regen table read wrong");

   property p_count_clear;
      @(posedge core_clk) disable iff (!rst_n)
      (clear_rd[0] && !learn_discard[0]) |=> discard_count[0] == 32'h0000_0000
         && reg_rsp.rdata == $past(discard_count[0]);
   endproperty
   a_count_clear: assert property (p_count_clear) else $error("Read did not return and clear count");

   property p_status_kept;
      @(posedge core_clk) disable iff (!rst_n)
      irq_pending_any |=> state_reg.pend_stage;
   endproperty
   a_status_kept: assert property (p_status_kept) else $error("Pending status lost");

   property p_mask_write;
      @(posedge core_clk) disable iff (!rst_n)
      (reg_req.wr && reg_req.addr == `OFS_IRQ_MASK) |=> state_reg.irq_mask == $past(reg_req.wdata[0]);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("Mask write lost");

   sequence s_regen_write;
      reg_req.wr && reg_req.addr == `OFS_PORT2_REGEN;
   endsequence

   sequence s_regen_read;
      reg_req.rd && reg_req.addr == `OFS_PORT2_REGEN;
   endsequence

   sequence s_pend_gone;
      !irq_pending_any;
   endsequence

   property p_regen_write;
      @(posedge core_clk) disable iff (!rst_n)
      s_regen_write |=> state_reg.regen_table == $past(reg_req.wdata[`REGEN_USED_W-1:0]);
   endproperty
   a_regen_write: assert property (p_regen_write) else $error("Table write lost");

   property p_regen_keep;
      @(posedge core_clk) disable iff (!rst_n)
      !(reg_req.wr && reg_req.addr == `OFS_PORT2_REGEN) |=> $stable(state_reg.regen_table);
   endproperty
   a_regen_keep: assert property (p_regen_keep) else $error("Table changed without write");

   property p_mask_keep;
      @(posedge core_clk) disable iff (!rst_n)
      !(reg_req.wr && reg_req.addr == `OFS_IRQ_MASK) |=> $stable(state_reg.irq_mask);
   endproperty
   a_mask_keep: assert property (p_mask_keep) else $error("Mask changed without write");

   property p_rsp_valid;
      @(posedge core_clk) disable iff (!rst_n)
      reg_req.rd |=> reg_rsp.valid;
   endproperty
   a_rsp_valid: assert property (p_rsp_valid) else $error("Read not answered");

   property p_rsp_idle;
      @(posedge core_clk) disable iff (!rst_n)
      !reg_req.rd |=> !reg_rsp.valid && reg_rsp.rdata == 32'h0000_0000;
   endproperty
   a_rsp_idle: assert property (p_rsp_idle) else $error("Response without read");

   property p_irq_drop;
      @(posedge core_clk) disable iff (!rst_n)
      s_pend_gone ##1 1'b1 |=> !switch_irq_req;
   endproperty
   a_irq_drop: assert property (p_irq_drop) else $error("Interrupt held without pending status");

   property p_mask_quiet;
      @(posedge core_clk) disable iff (!rst_n)
      state_reg.irq_mask |=> !switch_irq_req;
   endproperty
   a_mask_quiet: assert property (p_mask_quiet) else $error("Interrupt raised under mask");

   property p_pend_follows;
      @(posedge core_clk) disable iff (!rst_n)
      !irq_pending_any |=> !state_reg.pend_stage;
   endproperty
   a_pend_follows: assert property (p_pend_follows) else $error("Staged status set without source");

   property p_irq_needs_pend;
      @(posedge core_clk) disable iff (!rst_n)
      switch_irq_req |-> $past(state_reg.pend_stage) && !$past(state_reg.irq_mask);
   endproperty
   a_irq_needs_pend: assert property (p_irq_needs_pend) else $error("Interrupt without staged status");

   property p_mask_reset;
      @(posedge core_clk)
      $rose(rst_n) |-> state_reg.irq_mask && !switch_irq_req;
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("Mask not set after reset");

   property p_unmapped_read;
      @(posedge core_clk) disable iff (!rst_n)
      (reg_req.rd && !addr_mapped) |=> reg_rsp.valid && reg_rsp.rdata == 32'h0000_0000;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero");

   property p_unmapped_write;
      @(posedge core_clk) disable iff (!rst_n)
      (reg_req.wr && !addr_mapped)
         |=> $stable(state_reg.regen_table) && $stable(state_reg.irq_mask);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write) else $error("Unmapped write changed state");

   property p_regen_roundtrip;
      @(posedge core_clk) disable iff (!rst_n)
      s_regen_write ##1 !(reg_req.wr && reg_req.addr == `OFS_PORT2_REGEN) ##1 s_regen_read
         |=> reg_rsp.rdata == {8'h00, $past(reg_req.wdata[`REGEN_USED_W-1:0], 3)};
   endproperty
   a_regen_roundtrip: assert property (p_regen_roundtrip) else $error("Table read back wrong");

   property p_mask_roundtrip;
      @(posedge core_clk) disable iff (!rst_n)
      s_mask_write_seen ##1 !(reg_req.wr && reg_req.addr == `OFS_IRQ_MASK) ##1 s_mask_read
         |=> reg_rsp.rdata == {31'h0000_0000, $past(reg_req.wdata[`IRQ_MASK_BIT], 3)};
   endproperty
   a_mask_roundtrip: assert property (p_mask_roundtrip) else $error("Mask read back wrong");

   sequence s_mask_write_seen;
      reg_req.wr && reg_req.addr == `OFS_IRQ_MASK;
   endsequence
endmodule

// file: verilog/swe_regs_defines.svh
// Register offsets, field layout, reset values for the switch engine register slice
`ifndef SWE_REGS_DEFINES_SVH
`define SWE_REGS_DEFINES_SVH
`define OFS_PORT2_REGEN      16'h1857
`define OFS_PORT0_DISCARD    16'h1858
`define OFS_PORT1_DISCARD    16'h1859
`define OFS_PORT2_DISCARD    16'h185a
`define OFS_IRQ_MASK         16'h1880
`define REGEN_FIELD_W        3
`define REGEN_USED_W         24
`define RST_IRQ_MASK         1'b1
`define RST_REGEN_TABLE      24'hfac688
`define RST_DISCARD_COUNT    32'h0000_0000
`define DISCARD_COUNT_MAX    32'hffff_ffff
`define IRQ_MASK_BIT         0
`endif

// file: verilog/swe_regs_pkg.sv
// Types shared by the switch engine register slice
package swe_regs_pkg;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] rdata;
   } reg_rsp_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] prio;
   } prio_t;
endpackage

// file: verilog/discard_counter.sv
// Saturating clear-on-read learn discard counter
`timescale 1ns/10ps
`include "swe_regs_defines.svh"
module discard_counter (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        event_in,
   input  wire logic        clear_rd,
   output logic [31:0]      count
);
   import swe_regs_pkg::*;

   typedef struct packed {
      logic [31:0] count;
   } cnt_state_t;

   cnt_state_t state_reg;
   cnt_state_t state_next;

   always_comb begin
      state_next = state_reg;
      if (clear_rd) begin
         state_next.count = event_in ? 32'h0000_0001 : `RST_DISCARD_COUNT;
      end else if (event_in && state_reg.count != `DISCARD_COUNT_MAX) begin
         state_next.count = state_reg.count + 32'h0000_0001;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg.count <= `RST_DISCARD_COUNT;
      end else begin
         state_reg <= state_next;
      end
   end

   assign count = state_reg.count;

   property p_saturate;
      @(posedge core_clk) disable iff (!rst_n)
      (state_reg.count == `DISCARD_COUNT_MAX && !clear_rd) |=> state_reg.count == `DISCARD_COUNT_MAX;
   endproperty
   a_saturate: assert property (p_saturate) else $error("Discard counter wrapped");

   property p_count_up;
      @(posedge core_clk) disable iff (!rst_n)
      (event_in && !clear_rd && state_reg.count != `DISCARD_COUNT_MAX)
         |=> state_reg.count == $past(state_reg.count) + 32'h0000_0001;
   endproperty
   a_count_up: assert property (p_count_up) else $error("Discard counter missed an event");

   property p_no_wrap;
      @(posedge core_clk) disable iff (!rst_n)
      (state_reg.count != `RST_DISCARD_COUNT && !clear_rd) |=> state_reg.count != `RST_DISCARD_COUNT;
   endproperty
   a_no_wrap: assert property (p_no_wrap) else $error("Discard counter returned to zero unread");

   property p_reset_zero;
      @(posedge core_clk)
      $rose(rst_n) |-> state_reg.count == `RST_DISCARD_COUNT;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("Discard counter reset value wrong");
endmodule

// file: verilog/prio_regen_map.sv
// Port 2 received priority to regenerated priority lookup
`timescale 1ns/10ps
`include "swe_regs_defines.svh"
module prio_regen_map (
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   input  wire logic [23:0]              table_bits,
   input  wire swe_regs_pkg::prio_t      rx_prio,
   output swe_regs_pkg::prio_t           regen_prio
);
   import swe_regs_pkg::*;

   typedef struct packed {
      prio_t out;
   } map_state_t;

   map_state_t state_reg;
   map_state_t state_next;

   always_comb begin
      state_next.out.valid = rx_prio.valid;
      state_next.out.prio  = table_bits[rx_prio.prio * `REGEN_FIELD_W +: `REGEN_FIELD_W];
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign regen_prio = state_reg.out;

   property p_lookup;
      @(posedge core_clk) disable iff (!rst_n)
      rx_prio.valid |=> regen_prio.valid &&
         regen_prio.prio == $past(table_bits[rx_prio.prio * 3 +: 3]);
   endproperty
   a_lookup: assert property (p_lookup) else $error("Regenerated priority mismatch");
endmodule

// file: verification/swe_prio_learn_regs_tb_top.sv
// Self-checking testbench for the switch engine register slice
`timescale 1ns/10ps
`include "swe_regs_defines.svh"
module swe_prio_learn_regs_tb_top;
   import swe_regs_pkg::*;
   logic        core_clk;
   logic        rst_n;
   reg_req_t    reg_req;
   reg_rsp_t    reg_rsp;
   prio_t       rx_prio;
   prio_t       regen_prio;
   logic [2:0]  learn_discard;
   logic        irq_pending_any;
   logic        switch_irq_req;
   logic        switch_irq_mask_out;
   int          n_fail;
   int          checked;
   logic [31:0] tbl;
   logic [31:0] cnt [3];
   logic [2:0]  ev;

   swe_prio_learn_regs DUT (
      .core_clk            (core_clk),
      .rst_n               (rst_n),
      .reg_req             (reg_req),
      .reg_rsp             (reg_rsp),
      .rx_prio             (rx_prio),
      .regen_prio          (regen_prio),
      .learn_discard       (learn_discard),
      .irq_pending_any     (irq_pending_any),
      .switch_irq_req      (switch_irq_req),
      .switch_irq_mask_out (switch_irq_mask_out)
   );

   always #4 core_clk = ~core_clk;

   function automatic logic [2:0] field(input logic [31:0] t, input int k);
      return t[3*k +: 3];
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      reg_req.wr    = 1'b1;
      reg_req.addr  = a;
      reg_req.wdata = d;
      tick();
      reg_req.wr = 1'b0;
      tick();
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      reg_req.rd   = 1'b1;
      reg_req.addr = a;
      tick();
      reg_req.rd = 1'b0;
      check("read valid", 32'h1, {31'h0, reg_rsp.valid});
      check("read data", exp, reg_rsp.rdata);
      tick();
   endtask

   task automatic prio_all(input logic [31:0] t);
      for (int k = 0; k < 8; k++) begin
         rx_prio = '{valid: 1'b1, prio: 3'(k)};
         tick();
         rx_prio.valid = 1'b0;
         check("regen valid", 32'h1, {31'h0, regen_prio.valid});
         check("regen prio", {29'h0, field(t, k)}, {29'h0, regen_prio.prio});
         tick();
      end
   endtask

   task automatic results();
      if (n_fail == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(8 * 20000);
      n_fail++;
      results();
   end

   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      reg_req = '0;
      rx_prio = '0;
      learn_discard = 3'h0;
      irq_pending_any = 1'b0;
      n_fail = 0;
      checked = 0;
      void'($urandom(32'hfaccbf21));
      repeat (16) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      rd(`OFS_PORT2_REGEN, 32'h00fac688);
      rd(`OFS_IRQ_MASK, 32'h1);
      for (int p = 0; p < 3; p++) rd(`OFS_PORT0_DISCARD + 16'(p), 32'h0);
      prio_all(32'h00fac688);
      for (int i = 0; i < 3; i++) begin
         tbl = $urandom;
         wr(`OFS_PORT2_REGEN, tbl);
         tbl[31:24] = 8'h00;
         rd(`OFS_PORT2_REGEN, tbl);
         prio_all(tbl);
      end
      wr(16'h185b, 32'hffff_ffff);
      rd(16'h185b, 32'h0);
      rd(`OFS_PORT2_REGEN, tbl);
      wr(`OFS_IRQ_MASK, 32'h0000_0000);
      learn_discard = 3'h7;
      tick();
      learn_discard = 3'h0;
      rst_n = 1'b0;
      tick();
      rst_n = 1'b1;
      rd(`OFS_PORT2_REGEN, 32'h00fac688);
      rd(`OFS_IRQ_MASK, 32'h1);
      for (int p = 0; p < 3; p++) cnt[p] = 32'h0;
      for (int i = 0; i < 80; i++) begin
         ev = (i < 8) ? 3'h7 : 3'($urandom);
         learn_discard = ev;
         for (int p = 0; p < 3; p++) cnt[p] += 32'(ev[p]);
         tick();
      end
      learn_discard = 3'h0;
      tick();
      for (int p = 0; p < 3; p++) begin
         rd(`OFS_PORT0_DISCARD + 16'(p), cnt[p]);
         rd(`OFS_PORT0_DISCARD + 16'(p), 32'h0);
      end
      learn_discard = 3'h1;
      repeat (2) tick();
      reg_req.rd   = 1'b1;
      reg_req.addr = `OFS_PORT0_DISCARD;
      tick();
      reg_req.rd    = 1'b0;
      learn_discard = 3'h0;
      check("read with event", 32'h2, reg_rsp.rdata);
      tick();
      rd(`OFS_PORT0_DISCARD, 32'h1);
      rd(`OFS_PORT0_DISCARD, 32'h0);
      irq_pending_any = 1'b1;
      repeat (3) tick();
      check("irq masked", 32'h0, {31'h0, switch_irq_req});
      check("mask out", 32'h1, {31'h0, switch_irq_mask_out});
      wr(`OFS_IRQ_MASK, 32'hffff_fffe);
      rd(`OFS_IRQ_MASK, 32'h0);
      check("irq open", 32'h1, {31'h0, switch_irq_req});
      check("mask out", 32'h0, {31'h0, switch_irq_mask_out});
      irq_pending_any = 1'b0;
      repeat (3) tick();
      check("irq idle", 32'h0, {31'h0, switch_irq_req});
      irq_pending_any = 1'b1;
      tick();
      check("irq staged", 32'h0, {31'h0, switch_irq_req});
      tick();
      check("irq again", 32'h1, {31'h0, switch_irq_req});
      wr(`OFS_IRQ_MASK, 32'h1);
      tick();
      check("irq remasked", 32'h0, {31'h0, switch_irq_req});
      rd(`OFS_IRQ_MASK, 32'h1);
      results();
   end
endmodule
